// file: exec_defines.vh
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_KOFS 8'h04
`define OFS_PC 8'h08
`define OFS_ZPTR 8'h0C
`define OFS_SP 8'h10
`define OFS_STATUS_FLAGS_REG 8'h14
`define OFS_STAT 8'h18
`define OFS_RIDX 8'h1C
`define OFS_RDATA 8'h20
`define OFS_IOIDX 8'h24
`define OFS_IODATA 8'h28
`define OFS_RETW 8'h2C

// command word fields
`define CTL_OP_LSB 0
`define CTL_D_LSB 6
`define CTL_R_LSB 11
`define CTL_IMM_LSB 16
`define CTL_TWO_WORD 24

// status flag positions
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7

// reset values
`define PC_RST 16'h0000
`define ZPTR_RST 16'h0000
`define SP_RST 16'h000F
`define STATUS_FLAGS_REG_RST 8'h00

// operation codes
`define OP_SET_BITS 6'h00
`define OP_CLEAR_BITS 6'h01
`define OP_INC 6'h02
`define OP_DEC 6'h03
`define OP_ZERO_MINUS 6'h04
`define OP_REL_JUMP 6'h05
`define OP_PTR_JUMP 6'h06
`define OP_REL_CALL 6'h07
`define OP_PTR_CALL 6'h08
`define OP_CMP_SKIP_EQ 6'h09
`define OP_CMP_REGS 6'h0A
`define OP_CMP_CARRY 6'h0B
`define OP_CMP_IMM 6'h0C
`define OP_SKIP_RBIT_CLR 6'h0D
`define OP_SKIP_RBIT_SET 6'h0E
`define OP_SKIP_IOBIT_CLR 6'h0F
`define OP_SKIP_IOBIT_SET 6'h10
`define OP_BR_STAT_SET 6'h11
`define OP_BR_STAT_CLR 6'h12
`define OP_IO_BIT_SET 6'h13
`define OP_IO_BIT_CLR 6'h14
`define OP_SHL 6'h15
`define OP_SHR 6'h16
`define OP_ROL 6'h17
`define OP_BR_EQ 6'h18
`define OP_BR_NE 6'h19
`define OP_BR_CS 6'h1A
`define OP_BR_CC 6'h1B
`define OP_BR_SH 6'h1C
`define OP_BR_LO 6'h1D
`define OP_BR_MI 6'h1E
`define OP_BR_PL 6'h1F
`define OP_BR_GE 6'h20
`define OP_BR_LT 6'h21
`define OP_BR_HS 6'h22
`define OP_BR_HC 6'h23
`define OP_BR_TS 6'h24
`define OP_BR_TC 6'h25
`define OP_BR_VS 6'h26
`define OP_BR_VC 6'h27
`define OP_BR_IE 6'h28
`define OP_BR_ID 6'h29
`define OP_LAST 6'h29

// execution lengths in clocks
`define CYC_ONE 2'd1
`define CYC_JUMP 2'd2
`define CYC_CALL 2'd3
`define CYC_SKIP_SHORT 2'd2
`define CYC_SKIP_LONG 2'd3
`define CYC_BR_TAKEN 2'd2
`define CYC_IO_BIT 2'd2

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: flag_alu.v
`timescale 1ns/1ns
`include "exec_defines.vh"

module flag_alu (
  // operation and operands
  input wire [5:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [7:0] status_flags_reg_in,
  // result
  output reg [7:0] res,
  output reg [7:0] status_flags_reg_out,
  output reg wr_en
);

  reg [8:0] diff;
  reg cin;

  // zero, negative, overflow and sign from a result
  function [7:0] znv;
    input [7:0] s;
    input [7:0] r;
    input v;
    begin
      znv = s;
      znv[`FLG_Z] = (r == 8'h00);
      znv[`FLG_N] = r[7];
      znv[`FLG_V] = v;
      znv[`FLG_S] = r[7] ^ v;
    end
  endfunction

  always @* begin
    res = a;
    status_flags_reg_out = status_flags_reg_in;
    wr_en = 1'b0;
    diff = 9'h000;
    cin = 1'b0;
    case (op)
      `OP_SET_BITS: begin
        res = a | b;
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, 1'b0);
      end
      `OP_CLEAR_BITS: begin
        res = a & (8'hFF - b);
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, 1'b0);
      end
      `OP_INC: begin
        res = a + 8'h01;
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, res == 8'h80);
      end
      `OP_DEC: begin
        res = a - 8'h01;
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, res == 8'h7F);
      end
      `OP_ZERO_MINUS: begin
        // value unchanged, so no write back
        res = a & a;
        status_flags_reg_out = znv(status_flags_reg_in, res, 1'b0);
      end
      `OP_CMP_REGS, `OP_CMP_CARRY, `OP_CMP_IMM: begin
        cin = (op == `OP_CMP_CARRY) ? status_flags_reg_in[`FLG_C] : 1'b0;
        diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        res = diff[7:0];
        status_flags_reg_out = znv(status_flags_reg_in, res, (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]));
        // chained compare keeps zero only if all bytes matched
        if (op == `OP_CMP_CARRY)
          status_flags_reg_out[`FLG_Z] = (res == 8'h00) & status_flags_reg_in[`FLG_Z];
        status_flags_reg_out[`FLG_C] = diff[8];
        status_flags_reg_out[`FLG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        res = a;
      end
      `OP_SHL: begin
        res = {a[6:0], 1'b0};
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, res[7] ^ a[7]);
        status_flags_reg_out[`FLG_C] = a[7];
      end
      `OP_SHR: begin
        res = {1'b0, a[7:1]};
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, a[0]);
        status_flags_reg_out[`FLG_C] = a[0];
      end
      `OP_ROL: begin
        res = {a[6:0], status_flags_reg_in[`FLG_C]};
        wr_en = 1'b1;
        status_flags_reg_out = znv(status_flags_reg_in, res, res[7] ^ a[7]);
        status_flags_reg_out[`FLG_C] = a[7];
      end
      default: begin
        res = a;
      end
    endcase
  end

endmodule

// file: exec_core.v
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "exec_defines.vh"

// What this block does
// - set bits: or with mask, one clock
// - clear bits: and with inverted mask
// - increment, decrement; carry untouched
// - zero-minus check: flags from self-and
// - jumps: relative or pointer, two clocks
// - calls push return address, three clocks
// - compare-skip-equal skips on register match
// - compares subtract, set six flags only
// - skip on working register bit state
// - skip on I/O register bit state
// - generic status bit branches, one/two clocks
// - zero, carry, negative named branches
// - signed branches use negative xor overflow
// - half-carry, copy, overflow flag branches
// - branches on global interrupt enable flag
// - I/O bit set/clear, flags untouched
// - logical shifts insert zero, update flags
// - rotate left through carry
// - I/O bit ops reach lowest thirty-two
// - I/O bit ops touch only target bit
module exec_core (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // write address channel
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  integer i;
  // core state
  reg [7:0] work_r [0:31];
  reg [7:0] io_r [0:31];
  reg [15:0] stack_r [0:15];
  reg [15:0] pc_r;
  reg [15:0] zptr_r;
  reg [15:0] sp_r;
  reg [7:0] status_flags_reg_r;
  reg [11:0] kofs_r;
  reg [4:0] ridx_r;
  reg [4:0] ioidx_r;
  // latched command
  reg [5:0] cmd_op_r;
  reg [4:0] cmd_d_r;
  reg [4:0] cmd_r_r;
  reg [7:0] cmd_imm_r;
  reg cmd_two_r;
  reg start_r;
  reg [1:0] cnt_r;
  reg taken_r;
  reg illegal_r;
  reg [1:0] cycles_r;
  // bus slave state
  reg aw_full_r;
  reg w_full_r;
  reg [7:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire busy = start_r | (cnt_r != 2'd0);
  wire bus_we = aw_full_r & w_full_r & ~s_axi_bvalid & ~start_r;
  // write strobes pick which bytes take the new data; the old value survives in the others
  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) && (addr <= `OFS_RETW);
    end
  endfunction

  function [31:0] reg_value;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CTRL: reg_value = {7'h00, cmd_two_r, cmd_imm_r, cmd_r_r, cmd_d_r, cmd_op_r};
        `OFS_KOFS: reg_value = {20'h00000, kofs_r};
        `OFS_PC: reg_value = {16'h0000, pc_r};
        `OFS_ZPTR: reg_value = {16'h0000, zptr_r};
        `OFS_SP: reg_value = {16'h0000, sp_r};
        `OFS_STATUS_FLAGS_REG: reg_value = {24'h000000, status_flags_reg_r};
        `OFS_STAT: reg_value = {27'h0000000, cycles_r, illegal_r, taken_r, busy};
        `OFS_RIDX: reg_value = {27'h0000000, ridx_r};
        `OFS_RDATA: reg_value = {24'h000000, work_r[ridx_r]};
        `OFS_IOIDX: reg_value = {27'h0000000, ioidx_r};
        `OFS_IODATA: reg_value = {24'h000000, io_r[ioidx_r]};
        `OFS_RETW: reg_value = {16'h0000, stack_r[sp_r[3:0] + 4'h1]};
        default: reg_value = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] wval = (wdata_r & strb_mask) | (reg_value(waddr_r) & ~strb_mask);
  // branch decode: {is_branch, taken}
  function [1:0] br_test;
    input [5:0] op;
    input [2:0] sel;
    input [7:0] s;
    begin
      case (op)
        `OP_BR_STAT_SET: br_test = {1'b1, s[sel]};
        `OP_BR_STAT_CLR: br_test = {1'b1, ~s[sel]};
        `OP_BR_EQ: br_test = {1'b1, s[`FLG_Z]};
        `OP_BR_NE: br_test = {1'b1, ~s[`FLG_Z]};
        `OP_BR_CS, `OP_BR_LO: br_test = {1'b1, s[`FLG_C]};
        `OP_BR_CC, `OP_BR_SH: br_test = {1'b1, ~s[`FLG_C]};
        `OP_BR_MI: br_test = {1'b1, s[`FLG_N]};
        `OP_BR_PL: br_test = {1'b1, ~s[`FLG_N]};
        `OP_BR_GE: br_test = {1'b1, ~(s[`FLG_N] ^ s[`FLG_V])};
        `OP_BR_LT: br_test = {1'b1, s[`FLG_N] ^ s[`FLG_V]};
        `OP_BR_HS: br_test = {1'b1, s[`FLG_H]};
        `OP_BR_HC: br_test = {1'b1, ~s[`FLG_H]};
        `OP_BR_TS: br_test = {1'b1, s[`FLG_T]};
        `OP_BR_TC: br_test = {1'b1, ~s[`FLG_T]};
        `OP_BR_VS: br_test = {1'b1, s[`FLG_V]};
        `OP_BR_VC: br_test = {1'b1, ~s[`FLG_V]};
        `OP_BR_IE: br_test = {1'b1, s[`FLG_I]};
        `OP_BR_ID: br_test = {1'b1, ~s[`FLG_I]};
        default: br_test = 2'b00;
      endcase
    end
  endfunction
  // operands of the latched command
  wire [7:0] rd_val = work_r[cmd_d_r];
  wire [7:0] rr_val = work_r[cmd_r_r];
  // five-bit port field cannot leave the bit-addressable block
  wire [7:0] io_val = io_r[cmd_d_r];
  wire [2:0] bit_sel = cmd_imm_r[2:0];
  wire use_rr = (cmd_op_r == `OP_CMP_REGS) || (cmd_op_r == `OP_CMP_CARRY);
  wire [7:0] alu_b = use_rr ? rr_val : cmd_imm_r;
  wire [15:0] rel_tgt = pc_r + {{4{kofs_r[11]}}, kofs_r} + 16'h0001;
  wire [1:0] skip_cyc = cmd_two_r ? `CYC_SKIP_LONG : `CYC_SKIP_SHORT;
  wire [1:0] br = br_test(cmd_op_r, bit_sel, status_flags_reg_r);
  wire [7:0] alu_res;
  wire [7:0] alu_status_flags_reg;
  wire alu_we;

  flag_alu u_alu (
    .op(cmd_op_r),
    .a(rd_val),
    .b(alu_b),
    .status_flags_reg_in(status_flags_reg_r),
    .res(alu_res),
    .status_flags_reg_out(alu_status_flags_reg),
    .wr_en(alu_we)
  );
  reg [15:0] pc_nxt;
  reg [1:0] cyc_nxt;
  reg push_nxt;
  reg skip_nxt;
  reg io_we_nxt;
  reg [7:0] io_nxt;
  reg illegal_nxt;
  always @* begin
    pc_nxt = pc_r + 16'h0001;
    cyc_nxt = `CYC_ONE;
    push_nxt = 1'b0;
    skip_nxt = 1'b0;
    io_we_nxt = 1'b0;
    io_nxt = io_val;
    illegal_nxt = (cmd_op_r > `OP_LAST);
    case (cmd_op_r)
      `OP_REL_JUMP: begin
        pc_nxt = rel_tgt;
        cyc_nxt = `CYC_JUMP;
      end
      `OP_PTR_JUMP: begin
        pc_nxt = zptr_r;
        cyc_nxt = `CYC_JUMP;
      end
      `OP_REL_CALL: begin
        pc_nxt = rel_tgt;
        cyc_nxt = `CYC_CALL;
        push_nxt = 1'b1;
      end
      `OP_PTR_CALL: begin
        pc_nxt = zptr_r;
        cyc_nxt = `CYC_CALL;
        push_nxt = 1'b1;
      end
      `OP_CMP_SKIP_EQ: skip_nxt = (rd_val == rr_val);
      `OP_SKIP_RBIT_CLR: skip_nxt = ~rr_val[bit_sel];
      `OP_SKIP_RBIT_SET: skip_nxt = rr_val[bit_sel];
      `OP_SKIP_IOBIT_CLR: skip_nxt = ~io_val[bit_sel];
      `OP_SKIP_IOBIT_SET: skip_nxt = io_val[bit_sel];
      `OP_IO_BIT_SET: begin
        // whole-byte read-modify-write; the other seven bits are written back as read
        io_we_nxt = 1'b1;
        io_nxt = io_val | (8'h01 << bit_sel);
        cyc_nxt = `CYC_IO_BIT;
      end
      `OP_IO_BIT_CLR: begin
        io_we_nxt = 1'b1;
        io_nxt = io_val & ~(8'h01 << bit_sel);
        cyc_nxt = `CYC_IO_BIT;
      end
      default: begin
        if (br[1] && br[0]) begin
          pc_nxt = rel_tgt;
          cyc_nxt = `CYC_BR_TAKEN;
        end
      end
    endcase
    if (skip_nxt) begin
      pc_nxt = pc_r + {14'h0000, skip_cyc};
      cyc_nxt = skip_cyc;
    end
  end

  // core state: command execution has the cycle to itself
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        work_r[i] <= 8'h00;
        io_r[i] <= 8'h00;
      end
      for (i = 0; i < 16; i = i + 1) begin
        stack_r[i] <= 16'h0000;
      end
      pc_r <= `PC_RST;
      zptr_r <= `ZPTR_RST;
      sp_r <= `SP_RST;
      status_flags_reg_r <= `STATUS_FLAGS_REG_RST;
      kofs_r <= 12'h000;
      ridx_r <= 5'h00;
      ioidx_r <= 5'h00;
      cmd_op_r <= 6'h00;
      cmd_d_r <= 5'h00;
      cmd_r_r <= 5'h00;
      cmd_imm_r <= 8'h00;
      cmd_two_r <= 1'b0;
      start_r <= 1'b0;
      cnt_r <= 2'd0;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
      cycles_r <= 2'd0;
    end else begin
      start_r <= 1'b0;
      if (start_r) begin
        illegal_r <= illegal_nxt;
        if (!illegal_nxt) begin
          // flags only change through the alu; jumps and skips pass them on
          if (alu_we)
            work_r[cmd_d_r] <= alu_res;
          status_flags_reg_r <= alu_status_flags_reg;
          pc_r <= pc_nxt;
          if (push_nxt) begin
            stack_r[sp_r[3:0]] <= pc_r + 16'h0001;
            sp_r <= sp_r - 16'h0001;
          end
          if (io_we_nxt)
            io_r[cmd_d_r] <= io_nxt;
          taken_r <= skip_nxt | (br[1] & br[0]);
          cycles_r <= cyc_nxt;
          cnt_r <= cyc_nxt - 2'd1;
        end
      end else begin
        if (cnt_r != 2'd0)
          cnt_r <= cnt_r - 2'd1;
        if (bus_we) begin
          case (waddr_r)
            `OFS_CTRL: begin
              // a command while busy is dropped, not queued
              if (!busy) begin
                cmd_op_r <= wval[`CTL_OP_LSB +: 6];
                cmd_d_r <= wval[`CTL_D_LSB +: 5];
                cmd_r_r <= wval[`CTL_R_LSB +: 5];
                cmd_imm_r <= wval[`CTL_IMM_LSB +: 8];
                cmd_two_r <= wval[`CTL_TWO_WORD];
                start_r <= 1'b1;
              end
            end
            `OFS_KOFS: kofs_r <= wval[11:0];
            `OFS_PC: pc_r <= wval[15:0];
            `OFS_ZPTR: zptr_r <= wval[15:0];
            `OFS_SP: sp_r <= wval[15:0];
            `OFS_STATUS_FLAGS_REG: status_flags_reg_r <= wval[7:0];
            `OFS_RIDX: ridx_r <= wval[4:0];
            `OFS_RDATA: work_r[ridx_r] <= wval[7:0];
            `OFS_IOIDX: ioidx_r <= wval[4:0];
            `OFS_IODATA: io_r[ioidx_r] <= wval[7:0];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // axi4-lite slave handshakes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (bus_we) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(waddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= reg_value(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// file: exec_core_chk.sv
`timescale 1ns/1ns
`include "exec_defines.vh"
module exec_core_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // write side
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read side
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  a_rd_unmapped: assert property ((s_ar_take ##0 s_axi_araddr > 8'h2C) |=>
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("second write address accepted early");
  a_w_block: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready [*2])
    else $error("second write data accepted early");
endmodule

bind exec_core exec_core_chk i_chk (.clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: testbench.sv
`timescale 1ns/1ns
`include "exec_defines.vh"
module testbench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] d, st;
  logic [1:0] rsp;
  logic [5:0] op;
  logic [7:0] sin;
  logic tk;
  logic lazy = 1'h0;
  int bsel [20] = '{3, 3, 1, 1, 0, 0, 0, 0, 2, 2, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
  // taken polarity per branch entry
  logic [19:0] bpol = 20'h55995;

  exec_core i_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  always #5 clk = ~clk;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // a lazy master raises ready only once the answer is up
    s_axi_bready <= !lazy;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
      n++;
    end while (!(s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) && n < 100);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 100) num_errors++;
  endtask

  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !lazy;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
      n++;
    end while (!(s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) && n < 100);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 100) num_errors++;
  endtask

  // start a command and poll until idle
  task run(input logic [5:0] o, input logic [4:0] dd, rr, input logic [7:0] imm, input logic two);
    int n;
    n = 0;
    wr(`OFS_CTRL, {7'h00, two, imm, rr, dd, o});
    do begin
      rd(`OFS_STAT);
      n++;
    end while (d[0] !== 1'h0 && n < 20);
    st = d;
    if (n >= 20) num_errors++;
  endtask

  task alu(input logic [5:0] o, input logic [7:0] a, r, imm, si, er, es);
    wr(`OFS_RIDX, 32'h2);
    wr(`OFS_RDATA, {24'h0, r});
    wr(`OFS_RIDX, 32'h1);
    wr(`OFS_RDATA, {24'h0, a});
    wr(`OFS_STATUS_FLAGS_REG, {24'h0, si});
    run(o, 5'h01, 5'h02, imm, 1'h0);
    chk("alu cycles", st[4:3], 2'h1);
    rd(`OFS_RDATA);
    chk("alu result", d, er);
    rd(`OFS_STATUS_FLAGS_REG);
    chk("alu flags", d, es);
  endtask

  task jc(input logic [5:0] o, input logic [15:0] pc0, input logic [11:0] k,
          input logic [15:0] z, epc, input logic [1:0] ecy);
    wr(`OFS_PC, pc0);
    wr(`OFS_KOFS, k);
    wr(`OFS_ZPTR, z);
    run(o, 5'h00, 5'h00, 8'h00, 1'h0);
    rd(`OFS_PC);
    chk("jump pc", d, epc);
    chk("jump cycles", st[4:3], ecy);
  endtask

  task sk(input logic [5:0] o, input logic [4:0] dd, rr, input logic [7:0] imm,
          input logic two, input logic [1:0] inc);
    wr(`OFS_PC, 32'h10);
    run(o, dd, rr, imm, two);
    rd(`OFS_PC);
    chk("skip pc", d, 32'h10 + inc);
    chk("skip cycles", st[4:3], inc);
    chk("skip taken", st[1], inc != 2'h1);
  endtask

  task results;
    $display("comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    rd(`OFS_SP);
    chk("sp reset", d, 32'hF);
    chk("read resp", rsp, `RESP_OKAY);
    alu(`OP_SET_BITS, 8'h50, 8'h00, 8'h0F, 8'h09, 8'h5F, 8'h01);
    alu(`OP_CLEAR_BITS, 8'h8F, 8'h00, 8'h0F, 8'h00, 8'h80, 8'h14);
    alu(`OP_INC, 8'h7F, 8'h00, 8'h00, 8'h01, 8'h80, 8'h0D);
    alu(`OP_DEC, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03);
    alu(`OP_ZERO_MINUS, 8'hF0, 8'h00, 8'h00, 8'h08, 8'hF0, 8'h14);
    alu(`OP_SHL, 8'h81, 8'h00, 8'h00, 8'h20, 8'h02, 8'h39);
    alu(`OP_SHR, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1B);
    alu(`OP_ROL, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h19);
    alu(`OP_CMP_REGS, 8'h10, 8'h20, 8'h00, 8'h00, 8'h10, 8'h15);
    alu(`OP_CMP_IMM, 8'h80, 8'h00, 8'h01, 8'h00, 8'h80, 8'h38);
    alu(`OP_CMP_CARRY, 8'h05, 8'h05, 8'h00, 8'h03, 8'h05, 8'h35);
    $display("test alu done");
    for (int i = 0; i < 20; i++) begin
      for (int v = 0; v < 2; v++) begin
        op = (i < 2) ? 6'(`OP_BR_STAT_SET + i) : 6'(`OP_BR_EQ + i - 2);
        sin = v ? (8'h01 << bsel[i]) : 8'h00;
        tk = (v[0] == bpol[i]);
        wr(`OFS_STATUS_FLAGS_REG, {24'h0, sin});
        wr(`OFS_PC, 32'h100);
        // negative offset exercises sign extension
        wr(`OFS_KOFS, 32'hFFE);
        run(op, 5'h00, 5'h00, 8'(bsel[i]), 1'h0);
        rd(`OFS_PC);
        chk("branch pc", d, tk ? 32'hFF : 32'h101);
        chk("branch cycles", st[4:3], tk ? 2'h2 : 2'h1);
        chk("branch taken", st[1], tk);
        rd(`OFS_STATUS_FLAGS_REG);
        chk("branch flags", d, sin);
      end
    end
    $display("test branch done");
    wr(`OFS_STATUS_FLAGS_REG, 32'hA5);
    chk("write resp", rsp, `RESP_OKAY);
    jc(`OP_REL_JUMP, 16'h100, 12'h7FF, 16'h0, 16'h900, 2'h2);
    jc(`OP_PTR_JUMP, 16'h100, 12'h0, 16'h1234, 16'h1234, 2'h2);
    jc(`OP_REL_CALL, 16'h200, 12'hFFF, 16'h0, 16'h200, 2'h3);
    rd(`OFS_RETW);
    chk("return addr", d, 32'h201);
    jc(`OP_PTR_CALL, 16'h300, 12'h0, 16'h3456, 16'h3456, 2'h3);
    rd(`OFS_RETW);
    chk("return addr", d, 32'h301);
    rd(`OFS_SP);
    chk("stack ptr", d, 32'hD);
    rd(`OFS_STATUS_FLAGS_REG);
    chk("jump flags", d, 32'hA5);
    $display("test jump done");
    wr(`OFS_RIDX, 32'h1);
    wr(`OFS_RDATA, 32'h4);
    wr(`OFS_RIDX, 32'h2);
    wr(`OFS_RDATA, 32'h4);
    wr(`OFS_IOIDX, 32'h5);
    wr(`OFS_IODATA, 32'h4);
    sk(`OP_CMP_SKIP_EQ, 5'h01, 5'h02, 8'h00, 1'h1, 2'h3);
    sk(`OP_CMP_SKIP_EQ, 5'h01, 5'h00, 8'h00, 1'h1, 2'h1);
    sk(`OP_SKIP_RBIT_CLR, 5'h00, 5'h02, 8'h02, 1'h0, 2'h1);
    sk(`OP_SKIP_RBIT_SET, 5'h00, 5'h02, 8'h02, 1'h0, 2'h2);
    sk(`OP_SKIP_IOBIT_CLR, 5'h05, 5'h00, 8'h00, 1'h0, 2'h2);
    sk(`OP_SKIP_IOBIT_SET, 5'h05, 5'h00, 8'h02, 1'h1, 2'h3);
    rd(`OFS_STATUS_FLAGS_REG);
    chk("skip flags", d, 32'hA5);
    $display("test skip done");
    wr(`OFS_IOIDX, 32'h1F);
    wr(`OFS_IODATA, 32'hA5);
    run(`OP_IO_BIT_SET, 5'h1F, 5'h00, 8'h01, 1'h0);
    rd(`OFS_IODATA);
    chk("io set", d, 32'hA7);
    run(`OP_IO_BIT_CLR, 5'h1F, 5'h00, 8'h07, 1'h0);
    rd(`OFS_IODATA);
    chk("io clear", d, 32'h27);
    rd(`OFS_STATUS_FLAGS_REG);
    chk("io flags", d, 32'hA5);
    $display("test io done");
    lazy = 1'h1;
    rd(8'h30);
    chk("unmapped rresp", rsp, `RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    wr(8'h30, 32'h1);
    chk("unmapped bresp", rsp, `RESP_SLVERR);
    lazy = 1'h0;
    run(6'h2A, 5'h00, 5'h00, 8'h00, 1'h0);
    chk("illegal op", st[2], 1'h1);
    $display("test bus done");
    results();
  end

  // roughly twenty times the expected run length
  initial begin
    #300000;
    num_errors++;
    results();
  end
endmodule
